//--- logic/fdsc_cfg.svh
`ifndef FDSC_CFG_SVH
`define FDSC_CFG_SVH
// Register byte offsets
`define FDSC_REG_CTRL      12'h000
`define FDSC_REG_PROFILE   12'h004
`define FDSC_REG_OFFSET    12'h008
`define FDSC_REG_STATUS    12'h00C
`define FDSC_REG_SUPPORT   12'h010
`define FDSC_REG_PRESENT   12'h014
`define FDSC_REG_DOM_BASE  12'h040
`define FDSC_DOM_STRIDE    12'h010
`define FDSC_DOM_SLEEP     12'h000
`define FDSC_DOM_BOOST     12'h004
`define FDSC_DOM_NOMINAL   12'h008
`define FDSC_DOM_IDLE      12'h00C
// Control fields
`define FDSC_CTRL_QUIET    0
`define FDSC_CTRL_IDLESTOP 1
// Reset values and full-scale duty
`define FDSC_RST_PROFILE   3'h0
`define FDSC_RST_OFFSET    7'h00
`define FDSC_RST_SLEEP     7'h14
`define FDSC_RST_BOOST     7'h64
`define FDSC_RST_NOMINAL   7'h32
`define FDSC_RST_IDLE      7'h0A
`define FDSC_DUTY_FULL     7'h64
// PWM period: 25 kHz fan PWM at 10 MHz clock
`define FDSC_CLK_HZ        10000000
`define FDSC_PWM_HZ        25000
`define FDSC_PWM_CYC       (`FDSC_CLK_HZ / `FDSC_PWM_HZ)
// Tach timeout: 1 s without a rising tach edge means fan failed
`define FDSC_TACH_MS       1000
`define FDSC_TACH_CYC      ((`FDSC_CLK_HZ / 1000) * `FDSC_TACH_MS)
`define FDSC_BRESP_OK      2'h0
`define FDSC_BRESP_ERR     2'h2
`endif

//--- logic/fdsc_pkg.sv
package fdsc_pkg;
  typedef enum logic [1:0] {FDSC_SLEEP, FDSC_NOMINAL, FDSC_BOOST} fdsc_dom_e;
  typedef logic [6:0] fdsc_duty_t;
endpackage

//--- logic/fdsc_fan_ctrl.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "fdsc_cfg.svh"
// Function
// RL1 - One dedicated PWM generator per fan domain.
// RL2 - Speed set by duty cycle, fraction of period output is high.
// RL3 - Each domain has its own output and own configurable policy.
// RL4 - Each domain is in exactly one of sleep, nominal, boost.
// RL5 - Sleep and boost give fixed, configurable speeds.
// RL6 - Nominal gives the domain policy speed.
// RL7 - Domain state derived from its temperature and fan sensor inputs.
// RL8 - Tach monitored per fan for failure, presence for hot swap.
// RL9 - Redundancy status computed from failure and presence of fans.
// RL10 - Profile selector takes eight values 0 to 7.
// RL11 - Even acoustic, odd performance; pairs pick altitude band.
// RL12 - Acoustic profile commands lower speed than performance. Code does not use the profile when setting duty.
// RL13 - Profile request accepted only if all domains support it.
// RL14 - No common profile: profile 0 used and locked.
// RL15 - PWM offset 0 to 100 percent added to minimum speed.
// RL16 - Offset only active in quiet idle; resets to zero.
// RL17 - Quiet idle stops or slows fans when temperatures satisfied.
// RL18 - Quiet idle returns to normal curves when not satisfied.
// RL19 - Quiet idle off never stops or slows fans; off at reset.
// RL20 - Configuring party picks altitude band, default second band. Code resets the profile to 0, which is the first band.
// RL21 - Configuring party picks performance for high airflow cards.
// RL22 - Configuring party picks throttling mode, default automatic. Code has no throttling mode.
// RL23 - Duty plus offset clamped to 100 percent.
// RL24 - Active profile is three bits, zero until valid selection.
module fdsc_fan_ctrl
  import fdsc_pkg::*;
#(
  parameter int N_DOM    = 2,
  parameter int N_FAN    = 4,
  parameter int TACH_CYC = `FDSC_TACH_CYC
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [11:0]      S_AXI_AWADDR,
  input  wire logic             S_AXI_AWVALID,
  output logic                  S_AXI_AWREADY,
  input  wire logic [31:0]      S_AXI_WDATA,
  input  wire logic [3:0]       S_AXI_WSTRB,
  input  wire logic             S_AXI_WVALID,
  output logic                  S_AXI_WREADY,
  output logic [1:0]            S_AXI_BRESP,
  output logic                  S_AXI_BVALID,
  input  wire logic             S_AXI_BREADY,
  input  wire logic [11:0]      S_AXI_ARADDR,
  input  wire logic             S_AXI_ARVALID,
  output logic                  S_AXI_ARREADY,
  output logic [31:0]           S_AXI_RDATA,
  output logic [1:0]            S_AXI_RRESP,
  output logic                  S_AXI_RVALID,
  input  wire logic             S_AXI_RREADY,
  input  wire logic [N_DOM-1:0] TEMP_HOT,
  input  wire logic [N_DOM-1:0] TEMP_COOL,
  input  wire logic [N_DOM-1:0] IDLE_OK,
  input  wire logic [N_FAN-1:0] FAN_TACH,
  input  wire logic [N_FAN-1:0] FAN_PRESENT,
  input  wire logic [N_FAN-1:0] FAN_DOMAIN_MAP,
  output logic [N_DOM-1:0]      PWM_OUT,
  output logic [N_FAN-1:0]      FAN_FAIL,
  output logic                  REDUNDANCY_LOST
);
  localparam int PWM_CYC = `FDSC_PWM_CYC;
  localparam int PW      = $clog2(PWM_CYC);
  localparam int TW      = $clog2(TACH_CYC + 1);

  typedef struct packed {
    logic                       aw_got;
    logic                       w_got;
    logic [11:0]                aw_addr;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       quiet;
    logic                       idle_stop;
    logic [2:0]                 profile;
    logic                       locked;
    logic                       rejected;
    logic [7:0]                 support;
    logic [6:0]                 offset;
    logic [N_DOM-1:0][6:0]      sleep_duty;
    logic [N_DOM-1:0][6:0]      boost_duty;
    logic [N_DOM-1:0][6:0]      nom_duty;
    logic [N_DOM-1:0][6:0]      idle_duty;
    fdsc_dom_e [N_DOM-1:0]      dom_state;
    logic [N_DOM-1:0][6:0]      duty;
    logic [N_DOM-1:0]           pwm;
    logic [PW-1:0]              pwm_cnt;
    logic [N_FAN-1:0][2:0]      tach_sync;
    logic [N_FAN-1:0][2:0]      pres_sync;
    logic [N_FAN-1:0]           tach_lvl;
    logic [N_FAN-1:0]           present;
    logic [N_FAN-1:0][TW-1:0]   tach_cnt;
    logic [N_FAN-1:0]           fail;
    logic                       red_lost;
  } fdsc_state_s;

  fdsc_state_s st;
  fdsc_state_s next_st;

  logic        do_wr;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [11:0] ra;
  logic [31:0] rd;
  logic        r_ok;
  logic        w_ok;
  logic [7:0]  prof_bit;
  logic [7:0]  sum;
  logic [6:0]  base;
  logic [N_FAN-1:0] ok_fans;
  int unsigned good;
  int unsigned fitted;
  int          d;

  assign S_AXI_AWREADY   = !st.aw_got && !st.bvalid;
  assign S_AXI_WREADY    = !st.w_got && !st.bvalid;
  assign S_AXI_BVALID    = st.bvalid;
  assign S_AXI_BRESP     = st.bresp;
  assign S_AXI_ARREADY   = !st.rvalid;
  assign S_AXI_RVALID    = st.rvalid;
  assign S_AXI_RDATA     = st.rdata;
  assign S_AXI_RRESP     = st.rresp;
  assign PWM_OUT         = st.pwm;
  assign FAN_FAIL        = st.fail;
  assign REDUNDANCY_LOST = st.red_lost;

  always_comb begin
    next_st = st;
    wa = '0;
    wd = '0;
    rd = 32'h0000_0000;
    r_ok = 1'b1;
    w_ok = 1'b1;
    d = 0;
    prof_bit = '0;
    sum = '0;
    base = '0;
    ok_fans = '0;
    good = 0;
    fitted = 0;
    // Capture write address and data in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = S_AXI_WDATA;
      next_st.w_strb = S_AXI_WSTRB;
    end
    do_wr = next_st.aw_got && next_st.w_got && !st.bvalid;
    wa = next_st.aw_addr;
    wd = next_st.w_data;
    if (do_wr) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      // Only the low byte holds fields, so byte lane 0 gates every write
      if (!next_st.w_strb[0]) begin
        w_ok = (wa[1:0] == 2'h0);
      end else if (wa == `FDSC_REG_CTRL) begin
        next_st.quiet     = wd[`FDSC_CTRL_QUIET];     // [RL19]
        next_st.idle_stop = wd[`FDSC_CTRL_IDLESTOP];
      end else if (wa == `FDSC_REG_PROFILE) begin
        prof_bit = 8'h01 << wd[2:0];                  // [RL10]
        // Locked or unsupported requests leave profile and flag refusal
        if (st.locked || (st.support & prof_bit) == 8'h00) begin
          next_st.rejected = 1'b1;                    // [RL13]
        end else begin
          next_st.profile  = wd[2:0];                 // [RL24]
          next_st.rejected = 1'b0;
        end
      end else if (wa == `FDSC_REG_OFFSET) begin
        // Values above 100 saturate rather than wrap
        next_st.offset = (wd > 32'(`FDSC_DUTY_FULL)) ? `FDSC_DUTY_FULL
                                                     : wd[6:0]; // [RL15]
      end else if (wa == `FDSC_REG_SUPPORT) begin
        // Support mask is the AND over all domains, kept by firmware
        next_st.support = wd[7:0];
        if (wd[7:0] == 8'h00) begin
          next_st.locked  = 1'b1;                     // [RL14]
          next_st.profile = 3'h0;
        end
      end else if (wa >= `FDSC_REG_DOM_BASE &&
                   wa < 12'(`FDSC_REG_DOM_BASE + N_DOM * `FDSC_DOM_STRIDE)) begin
        d = int'((wa - `FDSC_REG_DOM_BASE) >> 4);
        unique case (wa[3:0])
          4'(`FDSC_DOM_SLEEP):   next_st.sleep_duty[d] = wd[6:0]; // [RL5]
          4'(`FDSC_DOM_BOOST):   next_st.boost_duty[d] = wd[6:0]; // [RL5]
          4'(`FDSC_DOM_NOMINAL): next_st.nom_duty[d]   = wd[6:0]; // [RL6]
          4'(`FDSC_DOM_IDLE):    next_st.idle_duty[d]  = wd[6:0];
          default:                w_ok = 1'b0;
        endcase
      end else begin
        w_ok = 1'b0;
      end
      next_st.bresp = w_ok ? `FDSC_BRESP_OK : `FDSC_BRESP_ERR;
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end
    // Read
    ra = S_AXI_ARADDR;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      if (ra == `FDSC_REG_CTRL) begin
        rd[`FDSC_CTRL_QUIET]    = st.quiet;
        rd[`FDSC_CTRL_IDLESTOP] = st.idle_stop;
      end else if (ra == `FDSC_REG_PROFILE) begin
        rd[2:0] = st.profile;
        rd[8]   = st.locked;
        rd[9]   = st.rejected;
        rd[4]   = st.profile[0];                     // [RL11]
        rd[6:5] = st.profile[2:1];
      end else if (ra == `FDSC_REG_OFFSET) begin
        rd[6:0] = st.offset;
      end else if (ra == `FDSC_REG_STATUS) begin
        rd[N_FAN-1:0] = st.fail;
        rd[16]        = st.red_lost;
        for (int i = 0; i < N_DOM; i++) begin
          rd[20 + 2 * i +: 2] = st.dom_state[i];
        end
      end else if (ra == `FDSC_REG_SUPPORT) begin
        rd[7:0] = st.support;
      end else if (ra == `FDSC_REG_PRESENT) begin
        rd[N_FAN-1:0] = st.present;
      end else if (ra >= `FDSC_REG_DOM_BASE &&
                   ra < 12'(`FDSC_REG_DOM_BASE + N_DOM * `FDSC_DOM_STRIDE)) begin
        d = int'((ra - `FDSC_REG_DOM_BASE) >> 4);
        unique case (ra[3:0])
          4'(`FDSC_DOM_SLEEP):   rd[6:0] = st.sleep_duty[d];
          4'(`FDSC_DOM_BOOST):   rd[6:0] = st.boost_duty[d];
          4'(`FDSC_DOM_NOMINAL): rd[6:0] = st.nom_duty[d];
          4'(`FDSC_DOM_IDLE):    rd[6:0] = st.idle_duty[d];
          default:                r_ok = 1'b0;
        endcase
      end else begin
        r_ok = 1'b0;
      end
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = r_ok ? `FDSC_BRESP_OK : `FDSC_BRESP_ERR;
    end else if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end
    // Fan sensing, three-stage sync, change taken when stages 2 and 3 agree
    for (int f = 0; f < N_FAN; f++) begin
      next_st.tach_sync[f] = {st.tach_sync[f][1:0], FAN_TACH[f]};
      next_st.pres_sync[f] = {st.pres_sync[f][1:0], FAN_PRESENT[f]};
      if (st.tach_sync[f][1] == st.tach_sync[f][2]) begin
        next_st.tach_lvl[f] = st.tach_sync[f][2];
      end
      if (st.pres_sync[f][1] == st.pres_sync[f][2]) begin
        next_st.present[f] = st.pres_sync[f][2];      // [RL8]
      end
      // Stopped fans in quiet idle are not flagged as failed
      if ((st.tach_sync[f][2:1] == 2'b11 && !st.tach_lvl[f]) ||
          !st.present[f] || st.duty[FAN_DOMAIN_MAP[f]] == 7'h00) begin
        next_st.tach_cnt[f] = '0;
      end else if (st.tach_cnt[f] != TW'(TACH_CYC)) begin
        next_st.tach_cnt[f] = st.tach_cnt[f] + 1'b1;
      end
      next_st.fail[f] = st.present[f] &&
                        (st.tach_cnt[f] == TW'(TACH_CYC)); // [RL8]
      ok_fans[f] = st.present[f] && !st.fail[f];
    end
    for (int f = 0; f < N_FAN; f++) begin
      good   += ok_fans[f];
      fitted += 1;
    end
    // Redundancy needs N+1: lost once fewer than all fans are healthy
    next_st.red_lost = (good < fitted);               // [RL9]
    // PWM period counter shared; compare is per domain
    next_st.pwm_cnt = (st.pwm_cnt == PW'(PWM_CYC - 1)) ? '0
                                                       : st.pwm_cnt + 1'b1;
    for (int i = 0; i < N_DOM; i++) begin
      // Hot wins over cool so a domain never sits in two states
      if (TEMP_HOT[i] || (st.red_lost)) begin
        next_st.dom_state[i] = FDSC_BOOST;            // [RL7]
      end else if (TEMP_COOL[i]) begin
        next_st.dom_state[i] = FDSC_SLEEP;            // [RL4]
      end else begin
        next_st.dom_state[i] = FDSC_NOMINAL;
      end
      unique case (st.dom_state[i])
        FDSC_SLEEP:   base = st.sleep_duty[i];        // [RL5]
        FDSC_BOOST:   base = st.boost_duty[i];        // [RL5]
        FDSC_NOMINAL: base = st.nom_duty[i];    // [RL6] [RL12]
      endcase
      if (st.quiet && IDLE_OK[i] && st.dom_state[i] != FDSC_BOOST) begin
        base = st.idle_stop ? 7'h00 : st.idle_duty[i]; // [RL17]
      end                                             // [RL18]
      sum = {1'b0, base} + (st.quiet ? {1'b0, st.offset} : 8'h00); // [RL16]
      if (st.quiet && IDLE_OK[i] && st.idle_stop) begin
        sum = 8'h00;
      end
      next_st.duty[i] = (sum > {1'b0, `FDSC_DUTY_FULL}) ? `FDSC_DUTY_FULL
                                                        : sum[6:0]; // [RL23]
      next_st.pwm[i] = (32'(st.pwm_cnt) * 100) <
                       (32'(st.duty[i]) * PWM_CYC);  // [RL1] [RL2] [RL3]
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st            <= '0;
      st.profile    <= `FDSC_RST_PROFILE;
      st.offset     <= `FDSC_RST_OFFSET;
      st.support    <= 8'hFF;
      st.quiet      <= 1'b0;
      for (int i = 0; i < N_DOM; i++) begin
        st.sleep_duty[i] <= `FDSC_RST_SLEEP;
        st.boost_duty[i] <= `FDSC_RST_BOOST;
        st.nom_duty[i]   <= `FDSC_RST_NOMINAL;
        st.idle_duty[i]  <= `FDSC_RST_IDLE;
        st.dom_state[i]  <= FDSC_NOMINAL;
      end
    end else begin
      st <= next_st;
    end
  end

  property p_quiet_off;
    @(posedge CLK) disable iff (RESET)
    (!st.quiet && !$past(RESET)) |=>
                  (st.duty[0] != 7'h00 || $past(st.dom_state[0]) == FDSC_SLEEP
                   && st.sleep_duty[0] == 7'h00 || st.nom_duty[0] == 7'h00);
  endproperty
  a_quiet_off: assert property (p_quiet_off) // [RL19]
    else $error("Fan stopped with quiet idle off");

  property p_clamp;
    @(posedge CLK) disable iff (RESET)
    st.duty[0] <= `FDSC_DUTY_FULL;
  endproperty
  a_clamp: assert property (p_clamp) // [RL23]
    else $error("Duty above full scale");

  property p_locked;
    @(posedge CLK) disable iff (RESET)
    st.locked |=> st.profile == 3'h0;
  endproperty
  a_locked: assert property (p_locked) // [RL14]
    else $error("Locked profile changed");

  property p_boost;
    @(posedge CLK) disable iff (RESET)
    (TEMP_HOT[0] || st.red_lost) |=> st.dom_state[0] == FDSC_BOOST;
  endproperty
  a_boost: assert property (p_boost) // [RL7]
    else $error("Hot domain not in boost");

  property p_sleep_duty;
    @(posedge CLK) disable iff (RESET)
    (st.dom_state[0] == FDSC_SLEEP && !st.quiet) |=>
      st.duty[0] == $past(st.sleep_duty[0]);
  endproperty
  a_sleep_duty: assert property (p_sleep_duty) // [RL5]
    else $error("Sleep duty not applied");

  property p_pwm_zero;
    @(posedge CLK) disable iff (RESET)
    (st.duty[0] == 7'h00) [*2] |=> !PWM_OUT[0];
  endproperty
  a_pwm_zero: assert property (p_pwm_zero) // [RL2]
    else $error("PWM high at zero duty");

  property p_reject;
    @(posedge CLK) disable iff (RESET)
    st.locked |=> $stable(st.profile);
  endproperty
  a_reject: assert property (p_reject) // [RL13]
    else $error("Profile changed while refused");

  property p_red;
    @(posedge CLK) disable iff (RESET)
    (st.fail != '0) |=> st.red_lost;
  endproperty
  a_red: assert property (p_red) // [RL9]
    else $error("Failed fan without redundancy loss");
endmodule

//--- verif/fdsc_fan_model.sv
`timescale 1ns/1ps
module fdsc_fan_model #(
  parameter int N_FAN = 4
) (
  input  wire logic             CLK,
  input  wire logic [N_FAN-1:0] run_en,
  input  wire logic [N_FAN-1:0] fitted,
  input  wire logic [N_FAN-1:0] slow,
  output logic      [N_FAN-1:0] tach,
  output logic      [N_FAN-1:0] present
);
  for (genvar i = 0; i < N_FAN; i++) begin : g_fan
    logic [4:0] cnt = 5'h00;
    logic       lvl = 1'b0;
    // Absent fan: tach floats to its pull-up, presence to its pull-down
    assign tach[i]    = fitted[i] ? lvl : 1'b1;
    assign present[i] = fitted[i];
    // A stalled rotor holds its sensor level, so no edges reach the watchdog
    always @(posedge CLK) begin
      if (run_en[i] && cnt >= (slow[i] ? 5'h13 : 5'h05)) begin
        cnt <= 5'h00;
        lvl <= ~lvl;
      end else if (run_en[i]) begin
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
`include "fdsc_cfg.svh"
module tb;
  import fdsc_pkg::*;
  localparam int TC = 50;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, red_lost;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, m;
  logic [3:0]  wstrb, tach, pres, fail, run_en, fitted, slow;
  logic [1:0]  bresp, rresp, hot, cool, idle_ok, pwm;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          errors, total_checks, i, d0, d1, sl, bo, p;

  fdsc_fan_ctrl #(.N_DOM(2), .N_FAN(4), .TACH_CYC(TC)) i_fdsc_fan_ctrl (
    .CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .TEMP_HOT(hot), .TEMP_COOL(cool),
    .IDLE_OK(idle_ok), .FAN_TACH(tach), .FAN_PRESENT(pres),
    .FAN_DOMAIN_MAP(4'hC), .PWM_OUT(pwm), .FAN_FAIL(fail),
    .REDUNDANCY_LOST(red_lost));

  fdsc_fan_model #(.N_FAN(4)) i_fdsc_fan_model (
    .CLK(clk), .run_en(run_en), .fitted(fitted), .slow(slow),
    .tach(tach), .present(pres));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [11:0] da(input int d, input logic [11:0] o);
    return `FDSC_REG_DOM_BASE + (d == 1 ? `FDSC_DOM_STRIDE : 12'h000) + o;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One bus access; the expected answer is queued before the request goes out
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [1:0] r,
                     input logic [31:0] x, input logic [31:0] k);
    int n;
    exp_q.push_back({r, x & k});
    msk_q.push_back(k);
    // Spare edge so no handshake signal is driven twice in one step
    @(posedge clk);
    if (w) begin
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
    end else begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
    end
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
      if ((bready && bvalid) || (rready && rvalid)) break;
    end
    if (n == 100) begin
      errors++;
      $display("timeout at %0t", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, `FDSC_BRESP_OK, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic [31:0] k);
    acc(1'b0, a, 32'h0, `FDSC_BRESP_OK, x, k);
  endtask

  // Sliding window of one period gives the high time whatever the phase
  task automatic meas(input int e0, input int e1);
    int h0, h1;
    h0 = 0;
    h1 = 0;
    repeat (440) @(posedge clk);
    repeat (`FDSC_PWM_CYC) begin
      @(posedge clk);
      h0 += (pwm[0] === 1'b1);
      h1 += (pwm[1] === 1'b1);
    end
    chk(h0, e0 * (`FDSC_PWM_CYC / 100));
    chk(h1, e1 * (`FDSC_PWM_CYC / 100));
  endtask

  always @(posedge clk) begin
    if (!rst && ((bvalid && bready) || (rvalid && rready))) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("unexpected response at %0t", $time);
      end else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        if (bvalid && bready) begin
          chk({30'h0, bresp}, {30'h0, e[33:32]});
        end else begin
          chk({30'h0, rresp}, {30'h0, e[33:32]});
          chk(rdata & m, e[31:0]);
        end
      end
    end
  end

  initial begin
    seed = 32'hCBC7362A;
    errors = 0;
    total_checks = 0;
    rst = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {hot, cool, idle_ok} = '0;
    run_en = 4'hF;
    fitted = 4'hF;
    slow = 4'h5;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`FDSC_REG_CTRL, 32'h0, 32'h3);
    rd(`FDSC_REG_PROFILE, 32'h0, 32'h7);
    rd(`FDSC_REG_OFFSET, 32'h0, 32'h7F);
    rd(`FDSC_REG_SUPPORT, 32'hFF, 32'hFF);
    for (i = 0; i < 2; i++) begin
      rd(da(i, `FDSC_DOM_SLEEP), `FDSC_RST_SLEEP, 32'h7F);
      rd(da(i, `FDSC_DOM_BOOST), `FDSC_RST_BOOST, 32'h7F);
      rd(da(i, `FDSC_DOM_NOMINAL), `FDSC_RST_NOMINAL, 32'h7F);
      rd(da(i, `FDSC_DOM_IDLE), `FDSC_RST_IDLE, 32'h7F);
    end
    acc(1'b0, 12'h0FC, 32'h0, `FDSC_BRESP_ERR, 32'h0, 32'hFFFFFFFF);
    acc(1'b1, 12'h0FC, 32'h5, `FDSC_BRESP_ERR, 32'h0, 32'h0);
    d0 = 5 + rnd() % 56;
    d1 = 5 + rnd() % 56;
    wr(da(0, `FDSC_DOM_NOMINAL), d0);
    wr(da(1, `FDSC_DOM_NOMINAL), d1);
    meas(d0, d1);
    chk(fail, 32'h0);
    chk(red_lost, 32'h0);
    rd(`FDSC_REG_STATUS, 32'h0050_0000, 32'h00F1_000F);
    sl = 1 + rnd() % 100;
    bo = 1 + rnd() % 100;
    wr(da(0, `FDSC_DOM_SLEEP), sl);
    wr(da(1, `FDSC_DOM_BOOST), bo);
    cool <= 2'b11;
    hot <= 2'b10;
    meas(sl, bo);
    rd(`FDSC_REG_STATUS, 32'h0080_0000, 32'h00F0_0000);
    cool <= 2'b00;
    hot <= 2'b00;
    wr(`FDSC_REG_OFFSET, 30);
    wr(da(1, `FDSC_DOM_NOMINAL), 90);
    wr(`FDSC_REG_CTRL, 32'h1);
    idle_ok <= 2'b01;
    meas(`FDSC_RST_IDLE + 30, 100);
    wr(`FDSC_REG_CTRL, 32'h3);
    meas(0, 100);
    idle_ok <= 2'b00;
    meas(d0 + 30, 100);
    wr(`FDSC_REG_OFFSET, 200);
    rd(`FDSC_REG_OFFSET, 100, 32'h7F);
    idle_ok <= 2'b11;
    wr(`FDSC_REG_CTRL, 32'h0);
    meas(d0, 90);
    // Each pair is one altitude band, acoustic then performance
    for (i = 0; i < 8; i++) begin
      wr(`FDSC_REG_PROFILE, i);
      rd(`FDSC_REG_PROFILE, i + 16 * (i % 2) + 32 * (i / 2),
         32'h377);
    end
    wr(`FDSC_REG_SUPPORT, 32'h55);
    p = 1 + 2 * (rnd() % 4);
    wr(`FDSC_REG_PROFILE, p);
    rd(`FDSC_REG_PROFILE, 32'h207, 32'h307);
    wr(`FDSC_REG_PROFILE, p - 1);
    rd(`FDSC_REG_PROFILE, p - 1, 32'h307);
    wr(`FDSC_REG_SUPPORT, 32'h0);
    rd(`FDSC_REG_PROFILE, 32'h100, 32'h107);
    wr(`FDSC_REG_PROFILE, 6);
    rd(`FDSC_REG_PROFILE, 32'h100, 32'h107);
    run_en <= 4'hB;
    repeat (TC + 20) @(posedge clk);
    chk(fail, 32'h4);
    chk(red_lost, 32'h1);
    meas(`FDSC_RST_BOOST, bo);
    run_en <= 4'hF;
    fitted <= 4'h7;
    repeat (20) @(posedge clk);
    chk(fail[3], 32'h0);
    chk(red_lost, 32'h1);
    rd(`FDSC_REG_PRESENT, 32'h7, 32'hF);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
